// >>> capture_model.sv
// capture device model: sync source and pixel-side stall
`timescale 1ns/1ps
`default_nettype none
module capture_model #(
	parameter int LINES    = 8,
	parameter int LINE_LEN = 24
) (
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic go,
	input  wire logic slow,
	input  wire logic pixel_input_strobe,
	output logic      vsync_b,
	output logic      hsync_b,
	output logic      stall
);
	int   cnt_reg;
	logic phase_reg;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg   <= 0;
			phase_reg <= 1'b0;
		end else begin
			phase_reg <= !phase_reg; // pixel phase is clock over two
			if (go)
				cnt_reg <= 1;
			else if (cnt_reg != 0 && cnt_reg < LINES * LINE_LEN)
				cnt_reg <= cnt_reg + 1;
			else
				cnt_reg <= 0;
		end
	end
	// both syncs come from here; idle high outside a frame
	assign vsync_b = !(cnt_reg inside {[1:4]});
	assign hsync_b = !(cnt_reg >= LINE_LEN && cnt_reg % LINE_LEN < 4);
	// no pixel on odd phases when slow: stall in the strobe's own cycle
	assign stall = slow && phase_reg && pixel_input_strobe;
endmodule : capture_model
`default_nettype wire

// >>> frame_seq_axil.sv
// axi4-lite register slave for the frame sequencer
`timescale 1ns/1ps
`default_nettype none
`include "frame_seq_regs.svh"
module frame_seq_axil (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic [5:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [5:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	output logic             wr_stb,
	output logic [5:0]       wr_addr,
	output logic [31:0]      wr_data,
	output logic [3:0]       wr_strb,
	output logic [5:0]       rd_addr,
	input  wire logic [31:0] rd_value,
	input  wire logic        rd_hit,
	input  wire logic        wr_hit
);
	logic        aw_have_reg, aw_have_next;
	logic        w_have_reg,  w_have_next;
	logic [5:0]  awa_reg,     awa_next;
	logic [31:0] wd_reg,      wd_next;
	logic [3:0]  ws_reg,      ws_next;
	logic        bvalid_reg,  bvalid_next;
	logic [1:0]  bresp_reg,   bresp_next;
	logic        rvalid_reg,  rvalid_next;
	logic [31:0] rdata_reg,   rdata_next;
	logic [1:0]  rresp_reg,   rresp_next;
	logic        do_write;

	assign awready = !aw_have_reg && !bvalid_reg;
	assign wready  = !w_have_reg && !bvalid_reg;
	assign arready = !rvalid_reg;
	assign bvalid  = bvalid_reg;
	assign bresp   = bresp_reg;
	assign rvalid  = rvalid_reg;
	assign rdata   = rdata_reg;
	assign rresp   = rresp_reg;
	assign wr_addr = awa_reg;
	assign wr_data = wd_reg;
	assign wr_strb = ws_reg;
	assign rd_addr = araddr;
	assign wr_stb  = do_write;

	always_comb begin
		aw_have_next = aw_have_reg;
		w_have_next  = w_have_reg;
		awa_next     = awa_reg;
		wd_next      = wd_reg;
		ws_next      = ws_reg;
		bvalid_next  = bvalid_reg;
		bresp_next   = bresp_reg;
		rvalid_next  = rvalid_reg;
		rdata_next   = rdata_reg;
		rresp_next   = rresp_reg;
		do_write     = aw_have_reg && w_have_reg;
		if (awvalid && awready) begin
			aw_have_next = 1'b1;
			awa_next     = awaddr;
		end
		if (wvalid && wready) begin
			w_have_next = 1'b1;
			wd_next     = wdata;
			ws_next     = wstrb;
		end
		if (do_write) begin
			aw_have_next = 1'b0;
			w_have_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = wr_hit ? `AXI_OKAY : `AXI_SLVERR;
		end else if (bvalid_reg && bready) begin
			bvalid_next = 1'b0;
		end
		if (arvalid && arready) begin
			rvalid_next = 1'b1;
			rdata_next  = rd_hit ? rd_value : 32'h0000_0000;
			rresp_next  = rd_hit ? `AXI_OKAY : `AXI_SLVERR;
		end else if (rvalid_reg && rready) begin
			rvalid_next = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			aw_have_reg <= 1'b0;
			w_have_reg  <= 1'b0;
			awa_reg     <= 6'h00;
			wd_reg      <= 32'h0000_0000;
			ws_reg      <= 4'h0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= 2'h0;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h0000_0000;
			rresp_reg   <= 2'h0;
		end else begin
			aw_have_reg <= aw_have_next;
			w_have_reg  <= w_have_next;
			awa_reg     <= awa_next;
			wd_reg      <= wd_next;
			ws_reg      <= ws_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
			rvalid_reg  <= rvalid_next;
			rdata_reg   <= rdata_next;
			rresp_reg   <= rresp_next;
		end
	end
endmodule : frame_seq_axil
`default_nettype wire

// >>> frame_seq_pkg.sv
// types shared by the frame sequencer files
package frame_seq_pkg;
	typedef enum logic [2:0] {
		SEL_NOT_EMPTY,
		SEL_QUARTER,
		SEL_HALF,
		SEL_3QUARTER,
		SEL_CODEC_NB
	} thr_sel_t;

	typedef enum logic [1:0] {
		END_AT_CODER,
		END_AT_HOST,
		RESTART_AT_HOST
	} frame_end_out_mode_t;

	typedef enum {
		V_IDLE,
		V_VERTICAL_DELAY_COUNT,
		V_HORIZONTAL_DELAY_COUNT,
		V_ACTIVE,
		V_FLUSH
	} vstate_t;
endpackage : frame_seq_pkg

// >>> frame_seq_regs.svh
// register offsets, field positions and constants of the frame sequencer
`ifndef FRAME_SEQ_REGS_SVH
`define FRAME_SEQ_REGS_SVH

`define OFS_CONTROL     6'h00
`define OFS_DMA_MASK    6'h04
`define OFS_FIRST_INTERRUPT_OUT_MASK   6'h08
`define OFS_FRAME_END_OUT_EN   6'h0c
`define OFS_VERTICAL_DELAY_COUNT      6'h10
`define OFS_HORIZONTAL_DELAY_COUNT      6'h14
`define OFS_FLAGS       6'h18
`define OFS_LEVEL       6'h1c
`define OFS_WORD_COUNT  6'h20
`define OFS_SECOND_INTERRUPT_OUT_MASK   6'h24

// control register bits
`define CTL_START       0
`define CTL_ENABLE      1
`define CTL_SLAVE       2
`define CTL_DECOMP      9

// flags register bits
`define FLG_LATE        0
`define FLG_VNA         1
`define FLG_FRAME_END_OUT      2
`define FLG_FLUSHED     3

// fifo thresholds in words
`define LVL_QUARTER     8'h20
`define LVL_HALF        8'h40
`define LVL_3QUARTER    8'h60
`define FIFO_DEPTH      8'h80

`define LATE_CLEAR      16'hffff
`define PREFETCH_LINES  16'h0009

`define AXI_OKAY        2'h0
`define AXI_SLVERR      2'h2

`endif

// >>> jpeg_frame_seq.sv
// frame sequencer: slave-mode sync counting, fifo thresholds, frame end
// Behaviour
// - first interrupt may be programmed to fire at three-quarters full
// - dma request selects not-empty, quarter, half or three-quarter level
// - active-low dma request at threshold; host takes 1, 32, 64 or 96 words
// - at compression end, flush the pipeline then stop writing the fifo
// - end-at-coder: level shows residual words; host reads exactly those
// - host-side end modes signal frame end after the last word leaves
// - frame end can also be routed to the second interrupt output
// - in slave mode both syncs are inputs driven by the capture device
// - vertical sync falling edge starts a frame when enable and start set
// - start sampled each vertical edge; zero ignores that edge
// - horizontal sync pulses counted up to vertical delay to first line
// - on active line count horizontal delay clocks to first pixel
// - delay expiry raises blank and strobes the first pixel in the same cycle
// - late flag set while decompression selected and fifo empty
// - master decompression drives vertical sync and prefetches 9 lines early
// - pipeline empty at flush end sets video-not-active; start still one restarts frame
// - compressed word count kept per frame, updated when the pipeline empties at flush end
`timescale 1ns/1ps
`default_nettype none
`include "frame_seq_regs.svh"
module jpeg_frame_seq #(
	parameter int HACTIVE = 640,
	parameter int VACTIVE = 240
) (
	input  wire logic        CLK,
	input  wire logic        RST_B,
	input  wire logic [5:0]  AWADDR,
	input  wire logic        AWVALID,
	output logic             AWREADY,
	input  wire logic [31:0] WDATA,
	input  wire logic [3:0]  WSTRB,
	input  wire logic        WVALID,
	output logic             WREADY,
	output logic [1:0]       BRESP,
	output logic             BVALID,
	input  wire logic        BREADY,
	input  wire logic [5:0]  ARADDR,
	input  wire logic        ARVALID,
	output logic             ARREADY,
	output logic [31:0]      RDATA,
	output logic [1:0]       RRESP,
	output logic             RVALID,
	input  wire logic        RREADY,
	input  wire logic        VSYNC_B_IN,
	input  wire logic        HSYNC_B_IN,
	output logic             VSYNC_B_OUT,
	output logic             VSYNC_OE,
	input  wire logic        STALL,
	input  wire logic        CODER_WRITE,
	input  wire logic        HOST_READ,
	input  wire logic        HOST_WRITE,
	input  wire logic        PIPE_EMPTY,
	output logic             PIXEL_INPUT_STROBE,
	output logic             BLANK,
	output logic             PIXEL_LATCH,
	output logic             CODER_FLUSH,
	output logic             CODER_WRITE_EN,
	output logic             PIPE_HOLD,
	output logic             PREFETCH,
	output logic             DMA_REQUEST_OUT_B,
	output logic             FIRST_INTERRUPT_OUT,
	output logic             SECOND_INTERRUPT_OUT,
	output logic             FRAME_END_OUT,
	output logic             HALF_LEVEL_OUT
);
	logic        wr_stb, rd_hit, wr_hit;
	logic [5:0]  wr_addr, rd_addr;
	logic [31:0] wr_data, rd_value;
	logic [3:0]  wr_strb;

	frame_seq_axil u_bus (
		.clk(CLK), .rst_b(RST_B),
		.awaddr(AWADDR), .awvalid(AWVALID), .awready(AWREADY),
		.wdata(WDATA), .wstrb(WSTRB), .wvalid(WVALID), .wready(WREADY),
		.bresp(BRESP), .bvalid(BVALID), .bready(BREADY),
		.araddr(ARADDR), .arvalid(ARVALID), .arready(ARREADY),
		.rdata(RDATA), .rresp(RRESP), .rvalid(RVALID), .rready(RREADY),
		.wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data),
		.wr_strb(wr_strb), .rd_addr(rd_addr), .rd_value(rd_value),
		.rd_hit(rd_hit), .wr_hit(wr_hit)
	);

	// sync pins cross from the capture device: three stages each
	logic [2:0] vs_sync_reg, vs_sync_next;
	logic [2:0] hs_sync_reg, hs_sync_next;
	logic       vs_fall, hs_fall;
	assign vs_sync_next = {vs_sync_reg[1:0], VSYNC_B_IN};
	assign hs_sync_next = {hs_sync_reg[1:0], HSYNC_B_IN};
	assign vs_fall = vs_sync_reg[2] && !vs_sync_reg[1];
	assign hs_fall = hs_sync_reg[2] && !hs_sync_reg[1];

	// software registers
	logic [15:0]  ctl_reg, ctl_next;
	frame_seq_pkg::thr_sel_t     dma_sel_reg, dma_sel_next;
	frame_seq_pkg::thr_sel_t     first_interrupt_out_sel_reg, first_interrupt_out_sel_next;
	logic         first_interrupt_out_en_reg, first_interrupt_out_en_next;
	frame_seq_pkg::frame_end_out_mode_t fe_mode_reg, fe_mode_next;
	logic         second_interrupt_out_fe_reg, second_interrupt_out_fe_next;
	logic [15:0]  vertical_delay_count_reg, vertical_delay_count_next;
	logic [15:0]  horizontal_delay_count_reg, horizontal_delay_count_next;
	logic         late_reg, late_next;
	logic         vna_reg, vna_next;
	logic         fe_reg, fe_next;
	logic         flushed_reg, flushed_next;
	logic [7:0]   level_reg, level_next;
	logic [31:0]  wcount_reg, wcount_next;
	logic [31:0]  wlast_reg, wlast_next;

	// video sequencing
	frame_seq_pkg::vstate_t vst_reg, vst_next;
	logic [15:0]  line_reg, line_next;
	logic [15:0]  clk_cnt_reg, clk_cnt_next;
	logic [15:0]  pix_reg, pix_next;
	logic         vs_out_reg, vs_out_next;

	logic start, enable, slave, decomp;
	assign start  = ctl_reg[`CTL_START];
	assign enable = ctl_reg[`CTL_ENABLE];
	assign slave  = ctl_reg[`CTL_SLAVE];
	assign decomp = ctl_reg[`CTL_DECOMP];

	function automatic logic level_hit(frame_seq_pkg::thr_sel_t s,
			logic [7:0] lvl);
		case (s)
			frame_seq_pkg::SEL_NOT_EMPTY: level_hit = lvl != 8'h00;
			frame_seq_pkg::SEL_QUARTER:   level_hit = lvl >= `LVL_QUARTER;
			frame_seq_pkg::SEL_HALF:      level_hit = lvl >= `LVL_HALF;
			frame_seq_pkg::SEL_3QUARTER:  level_hit = lvl >= `LVL_3QUARTER;
			default:                      level_hit = 1'b0;
		endcase
	endfunction : level_hit

	logic stall_now, frame_go, pix_last, word_in, word_out, last_out;
	assign stall_now = STALL;
	// a falling sync edge arms a frame only with enable and start both set
	assign frame_go = slave && vs_fall && enable && start;
	assign pix_last = pix_reg == 16'(HACTIVE - 1);
	assign word_in  = CODER_WRITE && CODER_WRITE_EN && !decomp &&
		level_reg != `FIFO_DEPTH;
	assign word_out = decomp ? (CODER_WRITE && level_reg != 8'h00) :
		(HOST_READ && level_reg != 8'h00);
	assign last_out = flushed_reg && word_out && level_reg == 8'h01;

	always_comb begin
		vst_next     = vst_reg;
		line_next    = line_reg;
		clk_cnt_next = clk_cnt_reg;
		pix_next     = pix_reg;
		vs_out_next  = vs_out_reg;
		flushed_next = flushed_reg;
		vna_next     = vna_reg;
		fe_next      = fe_reg;
		wcount_next  = wcount_reg;
		wlast_next   = wlast_reg;
		late_next    = late_reg;
		// the clear goes first so that a hardware set later in this cycle wins
		if (wr_stb && wr_addr == `OFS_FLAGS && wr_data[15:0] == `LATE_CLEAR) begin
			late_next = 1'b0;
			vna_next  = 1'b0;
			fe_next   = 1'b0;
		end
		level_next   = 8'(level_reg + {7'h00, word_in || (decomp && HOST_WRITE
			&& level_reg != `FIFO_DEPTH)} - {7'h00, word_out});
		if (word_in)
			wcount_next = wcount_reg + 32'h0000_0001;
		case (vst_reg)
			frame_seq_pkg::V_IDLE: begin
				if (frame_go || (!slave && start && enable && decomp)) begin
					vst_next     = frame_seq_pkg::V_VERTICAL_DELAY_COUNT;
					line_next    = 16'h0000;
					flushed_next = 1'b0;
					vna_next     = 1'b0;
					vs_out_next  = !slave;
				end
			end
			frame_seq_pkg::V_VERTICAL_DELAY_COUNT: begin
				if (hs_fall && !stall_now) begin
					line_next = line_reg + 16'h0001;
					if (line_reg + 16'h0001 >= vertical_delay_count_reg) begin
						vst_next     = frame_seq_pkg::V_HORIZONTAL_DELAY_COUNT;
						clk_cnt_next = 16'h0000;
					end
				end
				vs_out_next = 1'b0;
			end
			frame_seq_pkg::V_HORIZONTAL_DELAY_COUNT: begin
				if (!stall_now) begin
					clk_cnt_next = clk_cnt_reg + 16'h0001;
					if (clk_cnt_reg + 16'h0001 >= horizontal_delay_count_reg) begin
						vst_next = frame_seq_pkg::V_ACTIVE;
						pix_next = 16'h0000;
					end
				end
			end
			frame_seq_pkg::V_ACTIVE: begin
				if (!stall_now) begin
					pix_next = pix_reg + 16'h0001;
					if (pix_last) begin
						// the next line waits for its own sync edge
						if (line_reg - vertical_delay_count_reg + 16'h0001 >= 16'(VACTIVE))
							vst_next = frame_seq_pkg::V_FLUSH;
						else
							vst_next = frame_seq_pkg::V_VERTICAL_DELAY_COUNT;
					end
				end
			end
			frame_seq_pkg::V_FLUSH: begin
				if (PIPE_EMPTY) begin
					vst_next     = frame_seq_pkg::V_IDLE;
					flushed_next = 1'b1;
					vna_next     = 1'b1;
					wlast_next   = wcount_reg;
					wcount_next  = 32'h0000_0000;
					if (fe_mode_reg == frame_seq_pkg::END_AT_CODER)
						fe_next = 1'b1;
					if (decomp && start && !slave)
						vs_out_next = 1'b1;
				end
			end
			default: vst_next = frame_seq_pkg::V_IDLE;
		endcase
		if (last_out && fe_mode_reg != frame_seq_pkg::END_AT_CODER)
			fe_next = 1'b1;
		if (decomp && level_reg == 8'h00)
			late_next = 1'b1;
	end

	always_comb begin
		ctl_next      = ctl_reg;
		dma_sel_next  = dma_sel_reg;
		first_interrupt_out_sel_next = first_interrupt_out_sel_reg;
		first_interrupt_out_en_next  = first_interrupt_out_en_reg;
		fe_mode_next  = fe_mode_reg;
		second_interrupt_out_fe_next  = second_interrupt_out_fe_reg;
		vertical_delay_count_next   = vertical_delay_count_reg;
		horizontal_delay_count_next   = horizontal_delay_count_reg;
		wr_hit        = 1'b1;
		if (wr_stb && wr_strb[0]) begin
			case (wr_addr)
				`OFS_CONTROL:   ctl_next = wr_data[15:0];
				`OFS_DMA_MASK:  dma_sel_next =
					frame_seq_pkg::thr_sel_t'(wr_data[2:0]);
				`OFS_FIRST_INTERRUPT_OUT_MASK: begin
					first_interrupt_out_sel_next = frame_seq_pkg::thr_sel_t'(wr_data[2:0]);
					first_interrupt_out_en_next  = wr_data[3];
				end
				`OFS_FRAME_END_OUT_EN: fe_mode_next =
					frame_seq_pkg::frame_end_out_mode_t'(wr_data[1:0]);
				`OFS_SECOND_INTERRUPT_OUT_MASK: second_interrupt_out_fe_next = wr_data[0];
				`OFS_VERTICAL_DELAY_COUNT:    vertical_delay_count_next = wr_data[15:0];
				`OFS_HORIZONTAL_DELAY_COUNT:    horizontal_delay_count_next = wr_data[15:0];
				`OFS_FLAGS:     wr_hit = 1'b1;
				default:        wr_hit = 1'b0;
			endcase
		end else if (wr_stb) begin
			wr_hit = wr_addr <= `OFS_SECOND_INTERRUPT_OUT_MASK && wr_addr[1:0] == 2'h0;
		end
	end

	always_comb begin
		rd_hit   = 1'b1;
		rd_value = 32'h0000_0000;
		case (rd_addr)
			`OFS_CONTROL:    rd_value = {16'h0000, ctl_reg};
			`OFS_DMA_MASK:   rd_value = {29'h0, dma_sel_reg};
			`OFS_FIRST_INTERRUPT_OUT_MASK:  rd_value = {28'h0, first_interrupt_out_en_reg, first_interrupt_out_sel_reg};
			`OFS_FRAME_END_OUT_EN:  rd_value = {30'h0, fe_mode_reg};
			`OFS_SECOND_INTERRUPT_OUT_MASK:  rd_value = {31'h0, second_interrupt_out_fe_reg};
			`OFS_VERTICAL_DELAY_COUNT:     rd_value = {16'h0000, vertical_delay_count_reg};
			`OFS_HORIZONTAL_DELAY_COUNT:     rd_value = {16'h0000, horizontal_delay_count_reg};
			`OFS_FLAGS:      rd_value = {28'h0, flushed_reg, fe_reg, vna_reg,
				late_reg};
			`OFS_LEVEL:      rd_value = {24'h0, level_reg};
			`OFS_WORD_COUNT: rd_value = wlast_reg;
			default:         rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			vs_sync_reg  <= 3'h7;
			hs_sync_reg  <= 3'h7;
			ctl_reg      <= 16'h0000;
			dma_sel_reg  <= frame_seq_pkg::SEL_NOT_EMPTY;
			first_interrupt_out_sel_reg <= frame_seq_pkg::SEL_3QUARTER;
			first_interrupt_out_en_reg  <= 1'b0;
			fe_mode_reg  <= frame_seq_pkg::END_AT_CODER;
			second_interrupt_out_fe_reg  <= 1'b0;
			vertical_delay_count_reg   <= 16'h0000;
			horizontal_delay_count_reg   <= 16'h0000;
			late_reg     <= 1'b0;
			vna_reg      <= 1'b0;
			fe_reg       <= 1'b0;
			flushed_reg  <= 1'b0;
			level_reg    <= 8'h00;
			wcount_reg   <= 32'h0000_0000;
			wlast_reg    <= 32'h0000_0000;
			vst_reg      <= frame_seq_pkg::V_IDLE;
			line_reg     <= 16'h0000;
			clk_cnt_reg  <= 16'h0000;
			pix_reg      <= 16'h0000;
			vs_out_reg   <= 1'b0;
		end else begin
			vs_sync_reg  <= vs_sync_next;
			hs_sync_reg  <= hs_sync_next;
			ctl_reg      <= ctl_next;
			dma_sel_reg  <= dma_sel_next;
			first_interrupt_out_sel_reg <= first_interrupt_out_sel_next;
			first_interrupt_out_en_reg  <= first_interrupt_out_en_next;
			fe_mode_reg  <= fe_mode_next;
			second_interrupt_out_fe_reg  <= second_interrupt_out_fe_next;
			vertical_delay_count_reg   <= vertical_delay_count_next;
			horizontal_delay_count_reg   <= horizontal_delay_count_next;
			late_reg     <= late_next;
			vna_reg      <= vna_next;
			fe_reg       <= fe_next;
			flushed_reg  <= flushed_next;
			level_reg    <= level_next;
			wcount_reg   <= wcount_next;
			wlast_reg    <= wlast_next;
			vst_reg      <= vst_next;
			line_reg     <= line_next;
			clk_cnt_reg  <= clk_cnt_next;
			pix_reg      <= pix_next;
			vs_out_reg   <= vs_out_next;
		end
	end

	logic active;
	assign active = vst_reg == frame_seq_pkg::V_ACTIVE;
	assign PIXEL_INPUT_STROBE = active && !decomp;
	assign BLANK              = active;
	// the bus is only captured when the source did not stall this cycle
	assign PIXEL_LATCH   = active && !decomp && !stall_now;
	assign PIPE_HOLD     = stall_now;
	assign CODER_FLUSH   = vst_reg == frame_seq_pkg::V_FLUSH;
	assign CODER_WRITE_EN = vst_reg != frame_seq_pkg::V_IDLE;
	assign PREFETCH      = decomp && vst_reg == frame_seq_pkg::V_VERTICAL_DELAY_COUNT &&
		line_reg < vertical_delay_count_reg &&
		line_reg + `PREFETCH_LINES >= vertical_delay_count_reg;
	assign VSYNC_B_OUT   = !vs_out_reg;
	assign VSYNC_OE      = !slave;
	assign DMA_REQUEST_OUT_B = !level_hit(dma_sel_reg, level_reg);
	assign FIRST_INTERRUPT_OUT = first_interrupt_out_en_reg &&
		level_hit(first_interrupt_out_sel_reg, level_reg);
	assign SECOND_INTERRUPT_OUT = (second_interrupt_out_fe_reg && fe_reg) || late_reg;
	assign FRAME_END_OUT = fe_reg;
	assign HALF_LEVEL_OUT = level_reg >= `LVL_HALF;
endmodule : jpeg_frame_seq
`default_nettype wire

// >>> jpeg_frame_seq_bench.sv
// self-checking bench for the frame sequencer
`timescale 1ns/1ps
`default_nettype none
`include "frame_seq_regs.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin \
	fail_count++; \
	$display("FAIL t=%0t got=%h exp=%h", $time, a, e); end end
module jpeg_frame_seq_bench;
	logic        CLK, RST_B, AWVALID, WVALID, BREADY, ARVALID, RREADY;
	logic [5:0]  AWADDR, ARADDR;
	logic [31:0] WDATA, RDATA, rd;
	logic [3:0]  WSTRB;
	logic        AWREADY, WREADY, BVALID, ARREADY, RVALID;
	logic [1:0]  BRESP, RRESP, resp;
	logic        VSYNC_B_IN, HSYNC_B_IN, VSYNC_B_OUT, VSYNC_OE, STALL;
	logic        CODER_WRITE, HOST_READ, HOST_WRITE, PIPE_EMPTY;
	logic        PIXEL_INPUT_STROBE, BLANK, PIXEL_LATCH, CODER_FLUSH;
	logic        CODER_WRITE_EN, PIPE_HOLD, PREFETCH, DMA_REQUEST_OUT_B;
	logic        FIRST_INTERRUPT_OUT, SECOND_INTERRUPT_OUT;
	logic        FRAME_END_OUT, HALF_LEVEL_OUT, go, slow;
	int          fail_count, n_compared;
	int          pix = 0;
	// short lines keep the frame inside the model's sync pattern
	jpeg_frame_seq #(.HACTIVE(4), .VACTIVE(2)) dut_u (.CLK(CLK),
		.RST_B(RST_B), .AWADDR(AWADDR), .AWVALID(AWVALID),
		.AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
		.WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
		.ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
		.RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
		.VSYNC_B_IN(VSYNC_B_IN), .HSYNC_B_IN(HSYNC_B_IN),
		.VSYNC_B_OUT(VSYNC_B_OUT), .VSYNC_OE(VSYNC_OE), .STALL(STALL),
		.CODER_WRITE(CODER_WRITE), .HOST_READ(HOST_READ),
		.HOST_WRITE(HOST_WRITE), .PIPE_EMPTY(PIPE_EMPTY),
		.PIXEL_INPUT_STROBE(PIXEL_INPUT_STROBE), .BLANK(BLANK),
		.PIXEL_LATCH(PIXEL_LATCH), .CODER_FLUSH(CODER_FLUSH),
		.CODER_WRITE_EN(CODER_WRITE_EN), .PIPE_HOLD(PIPE_HOLD),
		.PREFETCH(PREFETCH), .DMA_REQUEST_OUT_B(DMA_REQUEST_OUT_B),
		.FIRST_INTERRUPT_OUT(FIRST_INTERRUPT_OUT),
		.SECOND_INTERRUPT_OUT(SECOND_INTERRUPT_OUT),
		.FRAME_END_OUT(FRAME_END_OUT), .HALF_LEVEL_OUT(HALF_LEVEL_OUT));
	capture_model #(.LINES(8), .LINE_LEN(24)) cap_u (.clk(CLK),
		.rst_b(RST_B), .go(go), .slow(slow),
		.pixel_input_strobe(PIXEL_INPUT_STROBE), .vsync_b(VSYNC_B_IN),
		.hsync_b(HSYNC_B_IN), .stall(STALL));
	initial begin
		CLK = 1'b0;
		forever #10 CLK = ~CLK;
	end
	always @(posedge CLK) if (PIXEL_LATCH === 1'b1) pix <= pix + 1;
	task automatic end_sim();
		$display("compared %0d mismatched %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim
	task automatic tmo();
		fail_count++;
		$display("FAIL t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
		end_sim();
	endtask : tmo
	// ready is looked at mid-cycle: inputs only move at rising edges
	task automatic ax(input bit wr, input logic [5:0] a,
		input logic [31:0] d);
		logic tk, w, r;
		int   n;
		r = 1'b0;
		@(posedge CLK);
		AWADDR <= a;
		ARADDR <= a;
		WDATA <= d;
		{AWVALID, WVALID, BREADY} <= {3{wr}};
		{ARVALID, RREADY} <= {2{!wr}};
		for (n = 0; n < 50 && !r; n++) begin
			@(negedge CLK);
			tk = wr ? AWREADY : ARREADY;
			w = WREADY && wr;
			r = wr ? BVALID : RVALID;
			rd = RDATA;
			resp = wr ? BRESP : RRESP;
			@(posedge CLK);
			if (tk) {AWVALID, ARVALID} <= 2'b00;
			if (w) WVALID <= 1'b0;
			if (r) {BREADY, RREADY} <= 2'b00;
		end
		if (!r) tmo();
	endtask : ax
	task automatic pulse(input logic [2:0] m);
		@(posedge CLK);
		{HOST_WRITE, HOST_READ, CODER_WRITE} <= m;
		@(posedge CLK);
		{HOST_WRITE, HOST_READ, CODER_WRITE} <= 3'h0;
		@(negedge CLK);
	endtask : pulse
	task automatic wt(ref logic s, input int lim);
		for (int n = 0; n < lim && s !== 1'b1; n++) @(negedge CLK);
		if (s !== 1'b1) tmo();
	endtask : wt
	task automatic frame_go();
		@(posedge CLK);
		go <= 1'b1;
		@(posedge CLK);
		go <= 1'b0;
	endtask : frame_go
	task automatic t_regs();
		`CHK(DMA_REQUEST_OUT_B, 1'b1)
		ax(1, `OFS_VERTICAL_DELAY_COUNT, 32'h2);
		ax(0, `OFS_VERTICAL_DELAY_COUNT, 32'h0);
		`CHK(rd, 32'h2)
		ax(0, 6'h3c, 32'h0);
		`CHK(resp, `AXI_SLVERR)
		`CHK(rd, 32'h0)
		$display("registers done");
	endtask : t_regs
	task automatic t_thr();
		int w[4] = '{1, 32, 64, 96};
		int k;
		ax(1, `OFS_FIRST_INTERRUPT_OUT_MASK, 32'hb);
		// no frame runs: the fifo is filled from the decompression side
		ax(1, `OFS_CONTROL, 32'h200);
		for (int i = 0; i < 4; i++) begin
			ax(1, `OFS_DMA_MASK, i);
			for (k = 0; k < 200 && DMA_REQUEST_OUT_B !== 1'b0; k++) pulse(3'h4);
			`CHK(k, w[i])
			`CHK(HALF_LEVEL_OUT, 1'(i >= 2))
			`CHK(FIRST_INTERRUPT_OUT, 1'(i == 3))
			repeat (w[i]) pulse(3'h1);
			`CHK(DMA_REQUEST_OUT_B, 1'b1)
		end
		ax(1, `OFS_CONTROL, 32'h0);
		ax(1, `OFS_FLAGS, 32'(`LATE_CLEAR));
		$display("thresholds done");
	endtask : t_thr
	task automatic t_frame();
		int p0;
		ax(1, `OFS_HORIZONTAL_DELAY_COUNT, 32'h3);
		ax(1, `OFS_SECOND_INTERRUPT_OUT_MASK, 32'h1);
		ax(1, `OFS_FRAME_END_OUT_EN, 32'h0);
		ax(1, `OFS_CONTROL, 32'h6); // sync enable before start
		ax(1, `OFS_CONTROL, 32'h7);
		`CHK(VSYNC_OE, 1'b0)
		p0 = pix;
		slow <= 1'b1;
		frame_go();
		wt(CODER_WRITE_EN, 400);
		repeat (3) pulse(3'h1);
		wt(CODER_FLUSH, 600);
		@(posedge CLK);
		PIPE_EMPTY <= 1'b1;
		wt(FRAME_END_OUT, 50);
		`CHK(pix - p0, 8)
		`CHK(CODER_WRITE_EN, 1'b0)
		`CHK(SECOND_INTERRUPT_OUT, 1'b1)
		ax(0, `OFS_WORD_COUNT, 32'h0);
		`CHK(rd, 32'h3)
		ax(0, `OFS_LEVEL, 32'h0);
		`CHK(rd, 32'h3)
		ax(1, `OFS_FRAME_END_OUT_EN, 32'h1);
		ax(1, `OFS_FLAGS, 32'(`LATE_CLEAR));
		repeat (2) pulse(3'h2);
		`CHK(FRAME_END_OUT, 1'b0)
		pulse(3'h2);
		`CHK(FRAME_END_OUT, 1'b1)
		$display("slave frame done");
	endtask : t_frame
	task automatic t_nostart();
		int p0;
		ax(1, `OFS_CONTROL, 32'h6);
		p0 = pix;
		frame_go();
		repeat (250) @(posedge CLK);
		`CHK(pix - p0, 0)
		`CHK(CODER_WRITE_EN, 1'b0)
		$display("start clear done");
	endtask : t_nostart
	task automatic t_late();
		ax(1, `OFS_CONTROL, 32'h200);
		ax(0, `OFS_FLAGS, 32'h0);
		`CHK(rd[`FLG_LATE], 1'b1)
		pulse(3'h4);
		ax(1, `OFS_FLAGS, 32'(`LATE_CLEAR));
		ax(0, `OFS_FLAGS, 32'h0);
		`CHK(rd[`FLG_LATE], 1'b0)
		$display("late flag done");
	endtask : t_late
	initial begin
		{AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
		{AWADDR, ARADDR, WDATA} = '0;
		WSTRB = 4'hf;
		{CODER_WRITE, HOST_READ, HOST_WRITE, PIPE_EMPTY, go, slow} = '0;
		RST_B = 1'b0;
		repeat (3) @(posedge CLK);
		RST_B <= 1'b1;
		t_regs();
		t_thr();
		t_frame();
		t_nostart();
		t_late();
		end_sim();
	end
endmodule : jpeg_frame_seq_bench
`default_nettype wire

// >>> jpeg_frame_seq_properties.sv
// assertions on the frame sequencer pixel, flush and dma pins
`timescale 1ns/1ps
`default_nettype none
module jpeg_frame_seq_properties (
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic STALL,
	input wire logic PIPE_EMPTY,
	input wire logic PIXEL_INPUT_STROBE,
	input wire logic BLANK,
	input wire logic PIXEL_LATCH,
	input wire logic PIPE_HOLD,
	input wire logic CODER_FLUSH,
	input wire logic PREFETCH,
	input wire logic DMA_REQUEST_OUT_B
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_B);
	sequence s_pix_stalled;
		PIXEL_INPUT_STROBE && STALL;
	endsequence
	sequence s_flush_done;
		CODER_FLUSH && PIPE_EMPTY;
	endsequence
	AST_HOLD: assert property (PIPE_HOLD == STALL)
		else $error("pipeline hold differs from stall");
	AST_LATCH: assert property (
		PIXEL_LATCH == (PIXEL_INPUT_STROBE && !STALL))
		else $error("pixel latch not strobe without stall");
	AST_FREEZE: assert property (s_pix_stalled |=> PIXEL_INPUT_STROBE)
		else $error("pixel window moved during stall");
	AST_BLANK: assert property (PIXEL_INPUT_STROBE |-> BLANK)
		else $error("strobe without blank high");
	AST_FLUSH_PIX: assert property (CODER_FLUSH |-> !PIXEL_INPUT_STROBE)
		else $error("pixels taken while flushing");
	AST_FLUSH_END: assert property (s_flush_done |=> !CODER_FLUSH)
		else $error("flush outlived empty pipeline");
	AST_PREFETCH: assert property (PREFETCH |-> !PIXEL_INPUT_STROBE)
		else $error("prefetch during compression pixels");
	AST_DRQ_RST: assert property ($rose(RST_B) |-> DMA_REQUEST_OUT_B)
		else $error("dma request active with empty fifo");
endmodule : jpeg_frame_seq_properties
bind jpeg_frame_seq jpeg_frame_seq_properties chk_u (.CLK(CLK),
	.RST_B(RST_B), .STALL(STALL), .PIPE_EMPTY(PIPE_EMPTY),
	.PIXEL_INPUT_STROBE(PIXEL_INPUT_STROBE), .BLANK(BLANK),
	.PIXEL_LATCH(PIXEL_LATCH), .PIPE_HOLD(PIPE_HOLD),
	.CODER_FLUSH(CODER_FLUSH), .PREFETCH(PREFETCH),
	.DMA_REQUEST_OUT_B(DMA_REQUEST_OUT_B));
`default_nettype wire
